/* File: hw/mie_pkg.sv */
// shared constants and types for the instruction execute block
// assumes one clock domain and a plain word-wide register port
package mie_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BUS_AW = 12;
   // register offsets (byte addresses, one word each)
   localparam logic [11:0] OFS_FLAGS = 12'h000;
   localparam logic [11:0] OFS_WORK = 12'h004;
   localparam logic [11:0] OFS_PC = 12'h008;
   localparam logic [11:0] OFS_WDOG = 12'h00C;
   localparam logic [11:0] OFS_MEM = 12'h100;
   // flag bit positions in the flags register
   localparam int FLG_C = 0;
   localparam int FLG_HC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_SLP = 3;
   localparam int FLG_EXP = 4;
   localparam int FLG_W = 5;
   // reset values
   localparam logic [4:0] RST_FLAGS = 5'h00;
   localparam logic [7:0] RST_WORK = 8'h00;
   // decimal adjust constants
   localparam logic [3:0] NIB_MAX = 4'h9;
   localparam logic [7:0] BCD_NONE = 8'h00;
   localparam logic [7:0] BCD_LO_FIX = 8'h06;
   localparam logic [7:0] BCD_HI_FIX = 8'h60;
   // a jump spends this many cycles, one of them a dummy slot
   localparam int unsigned GOTO_CYCLES = 2;

   typedef enum logic [2:0] {
      OP_INVERT_TO_WORKING = 3'h0,
      OP_BCD_ADJUST = 3'h1,
      OP_MEMORY_MINUS_ONE = 3'h2,
      OP_MINUS_ONE_TO_WORKING = 3'h3,
      OP_MEMORY_PLUS_ONE = 3'h4,
      OP_PLUS_ONE_TO_WORKING = 3'h5,
      OP_SLEEP = 3'h6,
      OP_GOTO = 3'h7
   } mie_op_e;

   // gray along run -> fill -> run and run -> sleep -> run
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_FILL = 2'h1,
      ST_SLEEP = 2'h2
   } mie_state_e;

   function automatic logic mie_is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction : mie_is_zero
endpackage : mie_pkg

/* File: hw/mie_alu_if.sv */
// operand and result bundle between the core and its ALU
// assumes the ALU is purely combinational
interface mie_alu_if;
   import mie_pkg::*;
   mie_op_e op;
   logic [7:0] operand;
   logic [7:0] working;
   logic carry_in;
   logic hc_in;
   logic [7:0] result;
   logic to_mem;
   logic to_work;
   logic zero_upd;
   logic zero_out;
   logic carry_upd;
   logic carry_out;
   modport alu (input op, operand, working, carry_in, hc_in,
      output result, to_mem, to_work, zero_upd, zero_out, carry_upd, carry_out);
   modport core (output op, operand, working, carry_in, hc_in,
      input result, to_mem, to_work, zero_upd, zero_out, carry_upd, carry_out);
endinterface : mie_alu_if

/* File: hw/mie_alu.sv */
// combinational ALU for the covered instruction subset
// assumes the caller qualifies every output with its own accept strobe
module mie_alu
   import mie_pkg::*;
(
   mie_alu_if.alu a
);
   logic lo_fix;
   logic hi_fix;
   logic [7:0] corr;
   logic [8:0] bcd_sum;

   always_comb begin
      lo_fix = (a.working[3:0] > NIB_MAX) || a.hc_in;
      hi_fix = (a.working[7:4] > NIB_MAX) || a.carry_in;
      corr = (lo_fix ? BCD_LO_FIX : BCD_NONE) | (hi_fix ? BCD_HI_FIX : BCD_NONE);
      bcd_sum = {1'b0, a.working} + {1'b0, corr};
      a.result = a.operand;
      a.to_mem = 1'b0;
      a.to_work = 1'b0;
      a.zero_upd = 1'b0;
      a.carry_upd = 1'b0;
      a.carry_out = a.carry_in | hi_fix | bcd_sum[8];
      unique case (a.op)
         OP_INVERT_TO_WORKING: begin
            a.result = ~a.operand;
            a.to_work = 1'b1;
            a.zero_upd = 1'b1;
         end
         OP_BCD_ADJUST: begin
            a.result = bcd_sum[7:0];
            a.to_mem = 1'b1;
            a.carry_upd = 1'b1;
         end
         OP_MEMORY_MINUS_ONE: begin
            a.result = a.operand - 8'h01;
            a.to_mem = 1'b1;
            a.zero_upd = 1'b1;
         end
         OP_MINUS_ONE_TO_WORKING: begin
            a.result = a.operand - 8'h01;
            a.to_work = 1'b1;
            a.zero_upd = 1'b1;
         end
         OP_MEMORY_PLUS_ONE: begin
            a.result = a.operand + 8'h01;
            a.to_mem = 1'b1;
            a.zero_upd = 1'b1;
         end
         OP_PLUS_ONE_TO_WORKING: begin
            a.result = a.operand + 8'h01;
            a.to_work = 1'b1;
            a.zero_upd = 1'b1;
         end
         OP_SLEEP, OP_GOTO: begin
            a.result = a.operand;
         end
      endcase
      a.zero_out = mie_is_zero(a.result);
   end
endmodule : mie_alu

/* File: hw/mie_wdog.sv */
// watchdog prescaler and counter with synchronous clear
// assumes run is low while the system clock is stopped
module mie_wdog
   import mie_pkg::*;
#(
   parameter int unsigned PRE_W = 8,
   parameter int unsigned CNT_W = 8
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic clear,
   output logic [CNT_W-1:0] count,
   output logic expire
);
   logic [PRE_W-1:0] pre_r;
   logic [CNT_W-1:0] cnt_r;
   logic pre_wrap;

   assign pre_wrap = &pre_r;
   assign count = cnt_r;
   assign expire = run && !clear && pre_wrap && (&cnt_r);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_r <= '0;
      end else if (clear) begin
         pre_r <= '0;
      end else if (run) begin
         pre_r <= pre_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (clear) begin
         cnt_r <= '0;
      end else if (run && pre_wrap) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule : mie_wdog

/* File: hw/mie_core.sv */
// execute stage for a subset of an 8-bit controller instruction set
// assumes instructions arrive decoded on op_* with a valid/ready handshake
// and that registers and data memory are also reached over a plain port
//
// How it works
// - The complement op inverts every bit of the addressed memory byte.
// - That result goes to the working register, memory stays, and only zero moves.
// - Decimal adjust adds 6 to the low nibble when it is above 9 or half carry is set.
// - Decimal adjust adds 6 to the high nibble when it is above 9 or carry is set.
// - Decimal adjust writes working plus 00h, 06h, 60h or 66h into the memory byte.
// - Decimal adjust leaves every flag but carry alone.
// - Decimal adjust sets carry when the high nibble is above 9 or carry was set, so bytes can chain.
// - Memory decrement writes the byte minus one back and updates zero.
// - Decrement to working puts byte minus one in working, memory kept, zero updated.
// - Memory increment writes the byte plus one back and updates zero.
// - Increment to working puts byte plus one in working, memory kept, zero updated.
// - The sleep op halts execution and stops the clock with all state kept.
// - The sleep op clears the watchdog counter and its prescaler.
// - The sleep op sets the sleep flag, clears expiry and touches no other flag.
// - A jump loads the target into the counter and costs two cycles with a dummy slot.
//
// Added by the designer: the plain strobed port and the register offsets.
module mie_core
   import mie_pkg::*;
#(
   parameter int unsigned MEM_AW = 6,
   parameter int unsigned PC_W = 12,
   parameter int unsigned WD_PRE_W = 8,
   parameter int unsigned WD_CNT_W = 8
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire mie_op_e op_code,
   input wire logic [MEM_AW-1:0] op_addr,
   input wire logic [PC_W-1:0] op_target,
   output logic op_ready,
   input wire logic wake,
   output logic sys_clk_en,
   output logic [PC_W-1:0] fetch_addr,
   input wire logic [BUS_AW-1:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata
);
   localparam int unsigned MEM_DEPTH = 1 << MEM_AW;

   mie_state_e state_r;
   mie_state_e state_nxt;
   logic [7:0] mem_q [MEM_DEPTH];
   logic [7:0] work_r;
   logic [FLG_W-1:0] flags_r;
   logic [PC_W-1:0] pc_r;
   logic [31:0] rdata_r;
   logic accept;
   logic [7:0] operand;
   logic [WD_CNT_W-1:0] wd_count;
   logic wd_expire;
   logic wd_clear;
   logic mem_hit;
   logic [MEM_AW-1:0] mem_idx;
   logic wr_flags;
   logic wr_work;
   logic wr_mem;

   mie_alu_if alu_bus ();

   // window decode for the data memory area of the register port
   function automatic logic in_mem(input logic [BUS_AW-1:0] adr);
      return (adr >= OFS_MEM) && (adr < OFS_MEM + BUS_AW'(4 * MEM_DEPTH));
   endfunction : in_mem

   assign mem_hit = in_mem(bus_addr);
   assign mem_idx = bus_addr[MEM_AW+1:2];
   assign wr_flags = bus_wr && (bus_addr == OFS_FLAGS);
   assign wr_work = bus_wr && (bus_addr == OFS_WORK);
   assign wr_mem = bus_wr && mem_hit;

   // no issue while halted or filling
   assign op_ready = (state_r == ST_RUN);
   assign accept = op_valid && op_ready;
   assign operand = mem_q[op_addr];
   assign fetch_addr = pc_r;
   assign bus_rdata = rdata_r;
   // system clock gated off in sleep
   assign sys_clk_en = (state_r != ST_SLEEP);
   assign wd_clear = accept && (op_code == OP_SLEEP);

   assign alu_bus.op = op_code;
   assign alu_bus.operand = operand;
   assign alu_bus.working = work_r;
   assign alu_bus.carry_in = flags_r[FLG_C];
   assign alu_bus.hc_in = flags_r[FLG_HC];

   mie_alu u_alu (
      .a(alu_bus)
   );

   mie_wdog #(
      .PRE_W(WD_PRE_W),
      .CNT_W(WD_CNT_W)
   ) u_wdog (
      .ref_clk(ref_clk),
      .rst(rst),
      .run(sys_clk_en),
      .clear(wd_clear),
      .count(wd_count),
      .expire(wd_expire)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: begin
            if (accept && op_code == OP_GOTO) begin
               state_nxt = ST_FILL;
            end else if (accept && op_code == OP_SLEEP) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_FILL: begin
            state_nxt = ST_RUN;
         end
         ST_SLEEP: begin
            if (wake) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // memory has no reset; an instruction write beats a port write
   always_ff @(posedge ref_clk) begin
      if (accept && alu_bus.to_mem) begin
         mem_q[op_addr] <= alu_bus.result;
      end else if (wr_mem) begin
         mem_q[mem_idx] <= bus_wdata[7:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         work_r <= RST_WORK;
      end else if (accept && alu_bus.to_work) begin
         work_r <= alu_bus.result;
      end else if (wr_work) begin
         work_r <= bus_wdata[7:0];
      end
   end

   // software write first, hardware updates after so a hardware set or clear wins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flags_r <= RST_FLAGS;
      end else begin
         if (wr_flags) begin
            flags_r <= bus_wdata[FLG_W-1:0];
         end
         if (accept && alu_bus.zero_upd) begin
            flags_r[FLG_Z] <= alu_bus.zero_out;
         end
         if (accept && alu_bus.carry_upd) begin
            flags_r[FLG_C] <= alu_bus.carry_out;
         end
         if (wd_expire) begin
            flags_r[FLG_EXP] <= 1'b1;
         end
         if (wd_clear) begin
            flags_r[FLG_SLP] <= 1'b1;
            flags_r[FLG_EXP] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pc_r <= '0;
      end else if (accept && op_code == OP_GOTO) begin
         pc_r <= op_target;
      end else if (accept) begin
         pc_r <= pc_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (bus_rd) begin
         if (bus_addr == OFS_FLAGS) begin
            rdata_r <= 32'(flags_r);
         end else if (bus_addr == OFS_WORK) begin
            rdata_r <= 32'(work_r);
         end else if (bus_addr == OFS_PC) begin
            rdata_r <= 32'(pc_r);
         end else if (bus_addr == OFS_WDOG) begin
            rdata_r <= 32'(wd_count);
         end else if (mem_hit) begin
            rdata_r <= 32'(mem_q[mem_idx]);
         end else begin
            rdata_r <= '0;
         end
      end else begin
         rdata_r <= '0;
      end
   end

   // checks, all on ref_clk with rst as disable
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   logic acc_inv;
   logic acc_bcd;
   logic acc_dec;
   logic acc_decw;
   logic acc_inc;
   logic acc_incw;
   logic acc_slp;
   logic acc_goto;
   assign acc_inv = accept && op_code == OP_INVERT_TO_WORKING;
   assign acc_bcd = accept && op_code == OP_BCD_ADJUST;
   assign acc_dec = accept && op_code == OP_MEMORY_MINUS_ONE;
   assign acc_decw = accept && op_code == OP_MINUS_ONE_TO_WORKING;
   assign acc_inc = accept && op_code == OP_MEMORY_PLUS_ONE;
   assign acc_incw = accept && op_code == OP_PLUS_ONE_TO_WORKING;
   assign acc_slp = accept && op_code == OP_SLEEP;
   assign acc_goto = accept && op_code == OP_GOTO;

   AST_INVERT_WORK: assert property (
      acc_inv |=> work_r == ~$past(operand))
      else $error("complement result wrong");

   AST_INVERT_KEEP: assert property (
      acc_inv && !wr_mem |=> mem_q[$past(op_addr)] == $past(operand)
         && flags_r[FLG_C] == $past(flags_r[FLG_C]))
      else $error("complement touched memory or carry");

   AST_BCD_LOW: assert property (
      acc_bcd && work_r[3:0] > NIB_MAX
      |=> mem_q[$past(op_addr)][3:0] == $past(work_r[3:0]) + 4'h6)
      else $error("low nibble not adjusted");

   AST_BCD_HIGH: assert property (
      acc_bcd && !flags_r[FLG_HC] && work_r[3:0] <= NIB_MAX && flags_r[FLG_C]
      |=> mem_q[$past(op_addr)][7:4] == $past(work_r[7:4]) + 4'h6)
      else $error("high nibble not adjusted");

   AST_BCD_PLAIN: assert property (
      acc_bcd && work_r == 8'h45 && flags_r[FLG_HC:FLG_C] == 2'h0
      |=> mem_q[$past(op_addr)] == 8'h45 && work_r == 8'h45)
      else $error("clean decimal value changed");

   AST_BCD_FLAGS: assert property (
      acc_bcd && !wr_flags
      |=> $stable(flags_r[FLG_EXP:FLG_HC]) || $past(wd_expire))
      else $error("adjust changed a flag other than carry");

   AST_BCD_CARRY: assert property (
      acc_bcd && work_r[7:4] > NIB_MAX |=> flags_r[FLG_C])
      else $error("decimal carry not set");

   AST_DEC_MEM: assert property (
      acc_dec |=> mem_q[$past(op_addr)] == $past(operand) - 8'h01)
      else $error("decrement in place wrong");

   AST_DECW: assert property (
      acc_decw && !wr_mem
      |=> work_r == $past(operand) - 8'h01 && mem_q[$past(op_addr)] == $past(operand))
      else $error("decrement to working wrong");

   AST_INC_MEM: assert property (
      acc_inc |=> mem_q[$past(op_addr)] == $past(operand) + 8'h01)
      else $error("increment in place wrong");

   AST_INCW: assert property (
      acc_incw && !wr_mem
      |=> work_r == $past(operand) + 8'h01 && mem_q[$past(op_addr)] == $past(operand))
      else $error("increment to working wrong");

   sequence s_asleep;
      !sys_clk_en && !op_ready;
   endsequence

   AST_SLEEP_HOLD: assert property (
      acc_slp ##1 !wake |=> s_asleep and ($stable(work_r) && $stable(pc_r)))
      else $error("sleep did not hold state");

   AST_WDOG_CLEAR: assert property (
      acc_slp |=> wd_count == '0)
      else $error("watchdog not cleared on sleep");

   AST_SLEEP_FLAGS: assert property (
      acc_slp && !wr_flags
      |=> flags_r[FLG_SLP] && !flags_r[FLG_EXP] && $stable(flags_r[FLG_Z:FLG_C]))
      else $error("sleep flag handling wrong");

   sequence s_goto_fill;
      !op_ready ##1 op_ready;
   endsequence

   AST_GOTO: assert property (
      acc_goto |=> s_goto_fill ##0 fetch_addr == $past(op_target, GOTO_CYCLES))
      else $error("jump target or timing wrong");

   AST_ZERO: assert property (
      (acc_decw || acc_incw || acc_inv) |=> flags_r[FLG_Z] == (work_r == 8'h00))
      else $error("zero flag disagrees with result");

   // adjust result goes to memory only, so working must not move
   AST_BCD_WORK_KEEP: assert property (
      acc_bcd && !wr_work |=> $stable(work_r))
      else $error("adjust changed the working register");

   // every taken op except a jump steps the fetch address by one
   AST_FETCH_STEP: assert property (
      accept && op_code != OP_GOTO |=> fetch_addr == $past(fetch_addr) + 1'b1)
      else $error("fetch address did not step");

   sequence s_woken;
      sys_clk_en && op_ready;
   endsequence

   AST_WAKE_RUN: assert property (
      !sys_clk_en && wake |=> s_woken)
      else $error("wake did not restart execution");

   // read data stand one cycle only, zero otherwise
   AST_RDATA_IDLE: assert property (
      !bus_rd |=> bus_rdata == 32'h0000_0000)
      else $error("read data not cleared after read cycle");
endmodule : mie_core

/* File: verif/tb_mie_core.sv */
// self-checking bench for the instruction execute block
// assumes the core alone, driven through its instruction port and register port
module tb_mie_core
   import mie_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk, rst, op_valid, wake, bus_wr, bus_rd, op_ready, sys_clk_en;
   mie_op_e op_code;
   logic [5:0] op_addr;
   logic [11:0] op_target, fetch_addr;
   logic [BUS_AW-1:0] bus_addr;
   logic [31:0] bus_wdata, bus_rdata;
   int fail_count, total_checks;

   // small watchdog so its counter moves within a short run
   mie_core #(.MEM_AW(6), .PC_W(12), .WD_PRE_W(2), .WD_CNT_W(2)) mie_core_i (
      .ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
      .op_target(op_target), .op_ready(op_ready), .wake(wake), .sys_clk_en(sys_clk_en),
      .fetch_addr(fetch_addr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask : bus_write

   // read data stand only in the cycle after the strobe
   task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : bus_read

   function automatic logic [11:0] maddr(input int i);
      return OFS_MEM + 12'(i * 4);
   endfunction : maddr

   // returns at the taking edge; ready is sampled on the falling edge before it
   task automatic exec(input mie_op_e op, input logic [5:0] a, input logic [11:0] t);
      int n;
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= op;
      op_addr <= a;
      op_target <= t;
      for (n = 0; n < 20; n++) begin
         @(negedge ref_clk);
         if (op_ready === 1'b1) break;
      end
      if (n == 20) check(32'h0, 32'h1, "instruction never taken");
      @(posedge ref_clk);
      op_valid <= 1'b0;
   endtask : exec

   task automatic t_reset();
      logic [31:0] d;
      check(32'({op_ready, sys_clk_en}), 32'h3, "ready and clock after reset");
      check(32'(fetch_addr), 32'h0, "counter after reset");
      bus_read(OFS_FLAGS, d);
      check(d, 32'h0, "flags after reset");
      bus_read(OFS_WORK, d);
      check(d, 32'h0, "working after reset");
      bus_write(OFS_PC, 32'h55);
      bus_read(OFS_PC, d);
      check(d, 32'h0, "counter is read only");
      bus_read(12'h0F0, d);
      check(d, 32'h0, "unmapped read");
      $display("test reset done");
   endtask : t_reset

   task automatic t_invert();
      logic [31:0] d;
      bus_write(maddr(3), 32'h5A);
      bus_write(maddr(4), 32'hFF);
      bus_write(OFS_FLAGS, 32'h07);
      exec(OP_INVERT_TO_WORKING, 6'd3, 12'h0);
      bus_read(OFS_WORK, d);
      check(d, 32'hA5, "inverted byte");
      bus_read(maddr(3), d);
      check(d, 32'h5A, "memory kept");
      bus_read(OFS_FLAGS, d);
      check(32'(d[3:0]), 32'h3, "only zero cleared");
      exec(OP_INVERT_TO_WORKING, 6'd4, 12'h0);
      bus_read(OFS_WORK, d);
      check(d, 32'h00, "inverted all ones");
      bus_read(OFS_FLAGS, d);
      check(32'(d[3:0]), 32'h7, "zero set");
      $display("test invert done");
   endtask : t_invert

   task automatic t_incdec();
      mie_op_e ops[5] = '{OP_MEMORY_PLUS_ONE, OP_MEMORY_MINUS_ONE, OP_MEMORY_MINUS_ONE,
         OP_MINUS_ONE_TO_WORKING, OP_PLUS_ONE_TO_WORKING};
      logic [7:0] init[5] = '{8'hFF, 8'h01, 8'h00, 8'h10, 8'h7F};
      logic [31:0] d;
      logic [7:0] e;
      logic w;
      for (int i = 0; i < 5; i++) begin
         e = (ops[i] inside {OP_MEMORY_PLUS_ONE, OP_PLUS_ONE_TO_WORKING}) ? init[i] + 8'h01 : init[i] - 8'h01;
         w = ops[i] inside {OP_MINUS_ONE_TO_WORKING, OP_PLUS_ONE_TO_WORKING};
         bus_write(maddr(10 + i), 32'(init[i]));
         bus_write(OFS_WORK, 32'h3C);
         // zero starts opposite to what the result should give
         bus_write(OFS_FLAGS, 32'({e != 8'h00, 2'b11}));
         exec(ops[i], 6'(10 + i), 12'h0);
         bus_read(maddr(10 + i), d);
         check(d, 32'(w ? init[i] : e), "memory after step");
         bus_read(OFS_WORK, d);
         check(d, 32'(w ? e : 8'h3C), "working after step");
         bus_read(OFS_FLAGS, d);
         check(32'(d[3:0]), 32'({e == 8'h00, 2'b11}), "flags after step");
      end
      $display("test incdec done");
   endtask : t_incdec

   task automatic t_bcd();
      logic [7:0] wv[7] = '{8'h45, 8'h4B, 8'h43, 8'hA2, 8'h12, 8'hAB, 8'h99};
      logic [6:0] cin = 7'b0010000;
      logic [6:0] hin = 7'b0000100;
      logic [7:0] em[7] = '{8'h45, 8'h51, 8'h49, 8'h02, 8'h72, 8'h11, 8'h99};
      logic [6:0] ec = 7'b0111000;
      logic [31:0] d;
      for (int i = 0; i < 7; i++) begin
         bus_write(OFS_WORK, 32'(wv[i]));
         bus_write(OFS_FLAGS, 32'({2'b11, hin[i], cin[i]}));
         exec(OP_BCD_ADJUST, 6'd20, 12'h0);
         bus_read(maddr(20), d);
         check(d, 32'(em[i]), "adjusted byte");
         bus_read(OFS_WORK, d);
         check(d, 32'(wv[i]), "working kept");
         bus_read(OFS_FLAGS, d);
         check(32'(d[3:0]), 32'({2'b11, hin[i], ec[i]}), "adjust flags");
      end
      $display("test bcd done");
   endtask : t_bcd

   task automatic t_goto();
      logic [31:0] d;
      bus_write(maddr(30), 32'h41);
      exec(OP_GOTO, 6'd0, 12'h123);
      #1 check(32'(fetch_addr), 32'h123, "jump target");
      check(32'(op_ready), 32'h0, "dummy slot");
      @(posedge ref_clk);
      #1 check(32'(op_ready), 32'h1, "ready after two cycles");
      exec(OP_MEMORY_PLUS_ONE, 6'd30, 12'h0);
      #1 check(32'(fetch_addr), 32'h124, "fetch resumes at target");
      bus_read(maddr(30), d);
      check(d, 32'h42, "byte after jump");
      $display("test goto done");
   endtask : t_goto

   task automatic t_sleep();
      logic [31:0] d;
      logic [11:0] pc;
      bus_write(maddr(5), 32'h77);
      bus_write(OFS_WORK, 32'h5C);
      bus_write(OFS_FLAGS, 32'h11);
      exec(OP_SLEEP, 6'd0, 12'h0);
      #1 pc = fetch_addr;
      check(32'({sys_clk_en, op_ready}), 32'h0, "halted");
      repeat (8) @(posedge ref_clk);
      bus_read(OFS_WDOG, d);
      check(d, 32'h0, "watchdog cleared");
      bus_read(OFS_FLAGS, d);
      check(32'(d[4:0]), 32'h09, "sleep flags");
      bus_read(OFS_WORK, d);
      check(d, 32'h5C, "working kept");
      bus_read(maddr(5), d);
      check(d, 32'h77, "memory kept");
      check(32'({sys_clk_en, op_ready, fetch_addr}), 32'(pc), "still halted");
      @(posedge ref_clk);
      wake <= 1'b1;
      @(posedge ref_clk);
      wake <= 1'b0;
      #1 check(32'({sys_clk_en, op_ready}), 32'h3, "woken");
      $display("test sleep done");
   endtask : t_sleep

   initial begin
      rst = 1'b1;
      op_valid = 1'b0;
      op_code = OP_INVERT_TO_WORKING;
      op_addr = '0;
      op_target = '0;
      wake = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = '0;
      bus_wdata = '0;
      fail_count = 0;
      total_checks = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1 t_reset();
      t_invert();
      t_incdec();
      t_bcd();
      t_goto();
      t_sleep();
      final_report();
   end

   // the tests need well under two thousand cycles
   initial begin
      #40000;
      fail_count++;
      $display("ERROR %0t: run did not finish", $time);
      final_report();
   end
endmodule : tb_mie_core
